// *** core/ovr_volume.sv ***
// Added by the designer: the Wishbone slave port.
`timescale 1ns/10ps
module ovr_volume import ovr_pkg::*; #(
  parameter int unsigned STEP_30MS_CYC = STEP_MAX_CYC
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [15:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output ovr_path_out_s [NPATH-1:0] path_o,
  output logic busy_o
);
  logic req;
  logic wr;
  ovr_idx_t idx;
  logic [NPATH-1:0] vol_hit;
  logic rate_hit;
  logic stat_hit;
  logic apply_req;
  logic apply_r;
  logic [RATE_W-1:0] rise_r;
  logic [RATE_W-1:0] fall_r;
  ovr_path_cfg_s [NPATH-1:0] cfg_r;
  ovr_cyc_t rise_cyc;
  ovr_cyc_t fall_cyc;
  logic [NPATH-1:0] busy_w;
  logic [31:0] rd_nxt;

  // cycles between fine steps for a rate code, scaled from the 30 ms one
  function automatic ovr_cyc_t step_cyc(input logic [RATE_W-1:0] s);
    int unsigned c;
    c = STEP_30MS_CYC * RATE_US[s] / RATE_US[7];
    if (RATE_US[s] != 0 && c == 0) begin
      c = 1;
    end
    return ovr_cyc_t'(c);
  endfunction : step_cyc

  // one request per ack; the gap cycle keeps a held stb from retriggering
  assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wr = req && wb_we_i;
  assign idx = wb_adr_i[15:2];
  assign rate_hit = (idx == RATE_IDX);
  assign stat_hit = (idx == STAT_IDX);

  // a one in bit 9 of any path register loads every path
  assign apply_req = wr && (|vol_hit) && wb_sel_i[1] &&
    wb_dat_i[APPLY_BIT];

  assign rise_cyc = step_cyc(rise_r);
  assign fall_cyc = step_cyc(fall_r);

  // bus acknowledge, one cycle after the request
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
    end else if (ce_i) begin
      wb_ack_o <= req;
    end
  end

  // read data is latched with ack; unmapped words read zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= '0;
    end else if (ce_i) begin
      wb_dat_o <= (req && !wb_we_i) ? rd_nxt : '0;
    end
  end

  // ramp rate fields; changing them mid-ramp alters the live slope
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rise_r <= RISE_RST;
      fall_r <= FALL_RST;
    end else if (ce_i && wr && rate_hit && wb_sel_i[0]) begin
      rise_r <= wb_dat_i[RISE_LSB +: RATE_W];
      fall_r <= wb_dat_i[FALL_LSB +: RATE_W];
    end
  end

  // update pulse, one cycle after the write that carried it
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      apply_r <= 1'b0;
    end else if (ce_i) begin
      apply_r <= apply_req;
    end
  end

  // summary of ramp activity for the busy pin; status reads each path's busy bit
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      busy_o <= 1'b0;
    end else if (ce_i) begin
      busy_o <= |busy_w;
    end
  end

  // read mux; bit 9 is a strobe and always reads zero
  always_comb begin
    rd_nxt = '0;
    if (rate_hit) begin
      rd_nxt[RISE_LSB +: RATE_W] = rise_r;
      rd_nxt[FALL_LSB +: RATE_W] = fall_r;
    end
    if (stat_hit) begin
      rd_nxt[NPATH-1:0] = busy_w;
    end
    for (int i = 0; i < NPATH; i++) begin
      if (vol_hit[i]) begin
        rd_nxt[GAIN_LSB +: GAIN_W] = cfg_r[i].gain;
        rd_nxt[MUTE_BIT] = cfg_r[i].mute;
      end
    end
  end

  // per path staging register and ramp engine
  // reserved codes are stored as written; keeping clear of them is the
  // host's job
  for (genvar g = 0; g < NPATH; g++) begin : g_path
    assign vol_hit[g] = (idx == VOL_IDX[g]);

    // staged settings; the live gain does not move until apply
    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        cfg_r[g] <= CFG_RST;
      end else if (ce_i && wr && vol_hit[g]) begin
        if (wb_sel_i[0]) begin
          cfg_r[g].gain <= wb_dat_i[GAIN_LSB +: GAIN_W];
        end
        if (wb_sel_i[1]) begin
          cfg_r[g].mute <= wb_dat_i[MUTE_BIT];
        end
      end
    end

    ovr_ramp u_ramp (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .ce_i(ce_i),
      .apply_i(apply_r),
      .cfg_i(cfg_r[g]),
      .rise_cyc_i(rise_cyc),
      .fall_cyc_i(fall_cyc),
      .out_o(path_o[g]),
      .busy_o(busy_w[g])
    );
  end

  ack_pulse_a: assert property (@(posedge clk_i) disable iff (rst_i)
    wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");
  ack_time_a: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("request not acknowledged next cycle");
  apply_gen_a: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && apply_req |=> apply_r ##1 !apply_r || apply_r)
    else $error("update strobe did not raise apply");
  apply_only_a: assert property (@(posedge clk_i) disable iff (rst_i)
    $rose(apply_r) |-> $past(apply_req) && $past(ce_i))
    else $error("apply without a written strobe");
  live_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && wr && vol_hit[0] && !apply_req && !apply_r && !busy_w[0]
      |=> $stable(path_o[0].fine_gain))
    else $error("stored write moved live gain");
  rate_reset_a: assert property (@(posedge clk_i)
    $past(rst_i) && !rst_i |-> rise_r == RISE_RST && fall_r == FALL_RST)
    else $error("ramp rates wrong after reset");
  cfg_reset_a: assert property (@(posedge clk_i)
    $past(rst_i) && !rst_i |->
      cfg_r[0] == CFG_RST && cfg_r[NPATH-1] == CFG_RST)
    else $error("path settings wrong after reset");
  mute_indep_a: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && wr && vol_hit[0] |=> $stable(cfg_r[1]))
    else $error("write to one path changed another");
  vol_read_a: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && req && !wb_we_i && vol_hit[2] |=>
      wb_dat_o[MUTE_BIT:0] == $past(cfg_r[2]) && !wb_dat_o[APPLY_BIT])
    else $error("path register read back wrong");
  gain_store_a: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && wr && vol_hit[4] && wb_sel_i[0] |=>
      cfg_r[4].gain == GAIN_W'($past(wb_dat_i)))
    else $error("gain write not stored");
  all_paths_a: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && apply_r && cfg_r[0] != CFG_RST && !cfg_r[0].mute &&
      cfg_r[NPATH-1] != CFG_RST && !cfg_r[NPATH-1].mute |=>
      !path_o[0].silence && !path_o[NPATH-1].silence)
    else $error("apply did not reach every path");
endmodule : ovr_volume

// *** core/ovr_pkg.sv ***
package ovr_pkg;
  localparam int NPATH = 9;
  localparam int IDX_W = 14;
  typedef logic [IDX_W-1:0] ovr_idx_t;
  // register indices; byte address is four times the index
  localparam ovr_idx_t RATE_IDX = 14'h0409;
  localparam ovr_idx_t STAT_IDX = 14'h0440;
  // path order 1L 1R 2L 2R 3 4L 4R 5L 5R
  localparam ovr_idx_t VOL_IDX [NPATH] = '{
    14'h0411, 14'h0415, 14'h0419, 14'h041D, 14'h0421,
    14'h0429, 14'h042D, 14'h0431, 14'h0435};
  localparam int RISE_LSB = 0;
  localparam int FALL_LSB = 4;
  localparam int RATE_W = 3;
  localparam int GAIN_LSB = 0;
  localparam int GAIN_W = 8;
  localparam int MUTE_BIT = 8;
  localparam int APPLY_BIT = 9;
  localparam logic [RATE_W-1:0] RISE_RST = 3'h2;
  localparam logic [RATE_W-1:0] FALL_RST = 3'h2;
  localparam logic MUTE_RST = 1'b1;
  localparam logic [GAIN_W-1:0] GAIN_RST = 8'h80;
  localparam int FINE_W = 10;
  localparam int FINE_PER_CODE = 4;
  localparam int FINE_PER_6DB = 48;
  localparam int CLK_NS = 100;
  // ramp time per 6 dB in microseconds, by rate code
  localparam int unsigned RATE_US [8] = '{
    0, 500, 1000, 2000, 4000, 8000, 15000, 30000};
  localparam int unsigned STEP_MAX_CYC =
    RATE_US[7] * 1000 / (CLK_NS * FINE_PER_6DB);
  localparam int CYC_W = 13;
  typedef logic [CYC_W-1:0] ovr_cyc_t;
  typedef logic [FINE_W-1:0] ovr_fine_t;
  typedef struct packed {
    logic mute;
    logic [GAIN_W-1:0] gain;
  } ovr_path_cfg_s;
  typedef struct packed {
    logic silence;
    ovr_fine_t fine_gain;
  } ovr_path_out_s;
  typedef enum {RMP_IDLE, RMP_UP, RMP_DOWN} ovr_ramp_e;
  localparam ovr_path_cfg_s CFG_RST = '{mute: MUTE_RST, gain: GAIN_RST};
endpackage : ovr_pkg

// *** core/ovr_ramp.sv ***
`timescale 1ns/10ps
module ovr_ramp import ovr_pkg::*; (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic apply_i,
  input ovr_path_cfg_s cfg_i,
  input ovr_cyc_t rise_cyc_i,
  input ovr_cyc_t fall_cyc_i,
  output ovr_path_out_s out_o,
  output logic busy_o
);
  ovr_ramp_e st_r;
  ovr_fine_t tgt_r;
  logic mute_r;
  ovr_cyc_t cnt_r;
  ovr_fine_t tgt_nxt;
  ovr_fine_t cur_nxt;
  ovr_cyc_t per;
  logic tick;

  // mute ramps to the floor; code times four gives 0.125 dB units
  assign tgt_nxt = cfg_i.mute ? '0 :
    ovr_fine_t'(cfg_i.gain) * ovr_fine_t'(FINE_PER_CODE);
  assign per = (st_r == RMP_UP) ? rise_cyc_i : fall_cyc_i;
  assign tick = (per == '0) || (cnt_r == per - 1'b1);
  assign busy_o = (st_r != RMP_IDLE);

  // one fine step per tick, zero rate jumps straight to target
  always_comb begin
    cur_nxt = out_o.fine_gain;
    if (per == '0) begin
      cur_nxt = tgt_r;
    end else if (st_r == RMP_UP) begin
      cur_nxt = out_o.fine_gain + 1'b1;
    end else if (st_r == RMP_DOWN) begin
      cur_nxt = out_o.fine_gain - 1'b1;
    end
  end

  // target only moves on the shared apply pulse
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tgt_r <= '0;
      mute_r <= MUTE_RST;
    end else if (ce_i && apply_i) begin
      tgt_r <= tgt_nxt;
      mute_r <= cfg_i.mute;
    end
  end

  // ramp sequencer; a new apply restarts from the present gain
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_r <= RMP_IDLE;
      cnt_r <= '0;
      out_o.fine_gain <= '0;
    end else if (ce_i) begin
      if (apply_i) begin
        cnt_r <= '0;
        if (tgt_nxt > out_o.fine_gain) begin
          st_r <= RMP_UP;
        end else if (tgt_nxt < out_o.fine_gain) begin
          st_r <= RMP_DOWN;
        end else begin
          st_r <= RMP_IDLE;
        end
      end else begin
        case (st_r)
          RMP_UP, RMP_DOWN: begin
            if (tick) begin
              cnt_r <= '0;
              out_o.fine_gain <= cur_nxt;
              if (cur_nxt == tgt_r) begin
                st_r <= RMP_IDLE;
              end
            end else begin
              cnt_r <= cnt_r + 1'b1;
            end
          end
          RMP_IDLE: cnt_r <= '0;
          default: st_r <= RMP_IDLE;
        endcase
      end
    end
  end

  // unmute releases at once; mute only silences once at the floor
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      out_o.silence <= 1'b1;
    end else if (ce_i) begin
      if (apply_i && !cfg_i.mute) begin
        out_o.silence <= 1'b0;
      end else if (!apply_i && mute_r && st_r == RMP_IDLE) begin
        out_o.silence <= 1'b1;
      end
    end
  end

  step_size_a: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && !apply_i && per != '0 |=>
      out_o.fine_gain == $past(out_o.fine_gain) ||
      out_o.fine_gain == $past(out_o.fine_gain) + 1'b1 ||
      out_o.fine_gain == $past(out_o.fine_gain) - 1'b1)
    else $error("fine gain moved more than one step");
  zero_jump_a: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && !apply_i && st_r != RMP_IDLE && per == '0 |=>
      out_o.fine_gain == $past(tgt_r) && st_r == RMP_IDLE)
    else $error("zero rate did not jump to target");
  step_space_a: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && !apply_i && !tick |=> $stable(out_o.fine_gain))
    else $error("gain stepped before its period ended");
  rise_mono_a: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && !apply_i && st_r == RMP_UP |=>
      out_o.fine_gain >= $past(out_o.fine_gain))
    else $error("rising ramp went down");
  mute_quiet_a: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && !apply_i && mute_r && st_r == RMP_IDLE |=>
      out_o.silence && out_o.fine_gain == '0)
    else $error("muted path not silent at floor");
  unmute_go_a: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && apply_i && !cfg_i.mute |=> !out_o.silence)
    else $error("unmute did not release silence");
endmodule : ovr_ramp

// *** verification/ovr_volume_tb.sv ***
`timescale 1ns/10ps
module ovr_volume_tb import ovr_pkg::*;;
  // short step spacing keeps ramps to a few dozen cycles
  localparam int unsigned STEP_P = 60;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic ce_i = 1'b1;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [15:0] wb_adr_i = 16'h0000;
  logic [3:0] wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h00000000;
  logic [31:0] wb_dat_o;
  logic wb_ack_o;
  ovr_path_out_s [NPATH-1:0] path_o;
  logic busy_o;
  int fails = 0;
  int check_count = 0;

  ovr_volume #(.STEP_30MS_CYC(STEP_P)) DUT (
    .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .path_o(path_o), .busy_o(busy_o)
  );

  // 10 MHz
  always #50 clk_i = ~clk_i;

  function automatic logic [15:0] adr_of(input ovr_idx_t x);
    return {x, 2'b00};
  endfunction : adr_of

  // distinct codes per path, both range ends on paths 0 and 1
  function automatic logic [7:0] gain_of(input int i);
    if (i == 0) return 8'hBF;
    if (i == 1) return 8'h00;
    return 8'h20 + 8'(i * 16);
  endfunction : gain_of

  task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("Error %0t: read %h expected %h", $time, got, exp);
    end
  endtask : chk_reg

  task automatic chk_path(input int i, input logic sil, input logic [9:0] f);
    check_count++;
    if (path_o[i].silence !== sil || path_o[i].fine_gain !== f) begin
      fails++;
      $display("Error %0t: path %0d gives %b/%0d expected %b/%0d", $time,
        i, path_o[i].silence, path_o[i].fine_gain, sil, f);
    end
  endtask : chk_path

  task automatic chk_bit(input logic got, input logic exp);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("Error %0t: flag %b expected %b", $time, got, exp);
    end
  endtask : chk_bit

  // one classic cycle; request held until ack is sampled high
  task automatic wb_xfer(input logic w, input logic [15:0] a,
                         input logic [31:0] d, output logic [31:0] q);
    int n;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_sel_i <= 4'h3;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 50);
    if (n >= 50) begin
      fails++;
      $display("Error %0t: no bus acknowledge", $time);
    end
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
  endtask : wb_xfer

  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb_xfer(1'b1, a, d, q);
  endtask : wr

  task automatic rd(input logic [15:0] a, input logic [31:0] exp);
    logic [31:0] q;
    wb_xfer(1'b0, a, 32'h00000000, q);
    chk_reg(q, exp);
  endtask : rd

  // apply a new code on one path, time the ramp and watch step size
  task automatic ramp(input int i, input logic [7:0] code,
                      input int lo, input int hi);
    logic [9:0] prev;
    logic [9:0] cur;
    logic big;
    logic saw_busy;
    int n;
    prev = path_o[i].fine_gain;
    big = 1'b0;
    saw_busy = 1'b0;
    wr(adr_of(VOL_IDX[i]), {22'h0, 2'b10, code});
    n = 0;
    while (path_o[i].fine_gain !== {code, 2'b00} && n < 200) begin
      @(posedge clk_i);
      n++;
      cur = path_o[i].fine_gain;
      if (busy_o === 1'b1) saw_busy = 1'b1;
      if (cur !== prev && cur !== prev + 10'h1 && cur !== prev - 10'h1)
        big = 1'b1;
      prev = cur;
    end
    chk_bit(big, 1'b0);
    chk_bit(n >= lo && n <= hi, 1'b1);
    chk_bit(saw_busy, 1'b1);
    repeat (3) @(posedge clk_i);
    chk_bit(busy_o, 1'b0);
  endtask : ramp

  task automatic report_and_stop;
    $display("checks %0d, mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : report_and_stop

  // whole run is under 2000 cycles; ten times that means a hang
  initial begin
    repeat (20000) @(posedge clk_i);
    fails++;
    $display("Error %0t: watchdog expired", $time);
    report_and_stop();
  end

  initial begin
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    for (int i = 0; i < NPATH; i++) chk_path(i, 1'b1, 10'h000);
    rd(adr_of(RATE_IDX), 32'h00000022);
    rd(adr_of(STAT_IDX), 32'h00000000);
    for (int i = 0; i < NPATH; i++) begin
      rd(adr_of(VOL_IDX[i]), 32'h00000180);
    end
    // unmapped place: ignored and reads zero
    wr(16'h0000, 32'h0000FFFF);
    rd(16'h0000, 32'h00000000);
    wr(adr_of(RATE_IDX), 32'h00000077);
    rd(adr_of(RATE_IDX), 32'h00000077);
    wr(adr_of(RATE_IDX), 32'h00000000);
    rd(adr_of(RATE_IDX), 32'h00000000);
    // stage unmuted codes on all paths, no apply yet; no reserved codes
    for (int i = 0; i < NPATH; i++) begin
      wr(adr_of(VOL_IDX[i]), {24'h0, gain_of(i)});
    end
    rd(adr_of(VOL_IDX[0]), 32'h000000BF);
    rd(adr_of(VOL_IDX[1]), 32'h00000000);
    repeat (10) @(posedge clk_i);
    chk_path(0, 1'b1, 10'h000);
    wr(adr_of(VOL_IDX[4]), {22'h0, 2'b10, gain_of(4)});
    rd(adr_of(VOL_IDX[4]), {24'h0, gain_of(4)});
    repeat (10) @(posedge clk_i);
    for (int i = 0; i < NPATH; i++) begin
      chk_path(i, 1'b0, {gain_of(i), 2'b00});
    end
    // mute one path only, applied from another register
    wr(adr_of(VOL_IDX[2]), {23'h0, 1'b1, gain_of(2)});
    repeat (10) @(posedge clk_i);
    chk_path(2, 1'b0, {gain_of(2), 2'b00});
    wr(adr_of(VOL_IDX[8]), {22'h0, 2'b10, gain_of(8)});
    repeat (10) @(posedge clk_i);
    chk_path(2, 1'b1, 10'h000);
    chk_path(3, 1'b0, {gain_of(3), 2'b00});
    // rise 4 cycles per step, fall 1; rates set only while idle
    wr(adr_of(RATE_IDX), 32'h00000013);
    ramp(3, gain_of(3) + 8'h02, 28, 40);
    ramp(3, gain_of(3), 6, 14);
    rd(adr_of(STAT_IDX), 32'h00000000);
    report_and_stop();
  end
endmodule : ovr_volume_tb
